// >>> scp_map.svh
// Notes on behaviour
// - Count up to terminal count, then wrap to zero, float
// - Step bit address on every valid clock rise
// - Chip enable high: standby, address held
// - Chip enable high keeps output floating
// - Reset input polarity set by programmed option
// - Reset active: address zero, output floating
// - Default polarity active high; low preferred
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH
`define SCP_ADDR_W      20
`define SCP_DEPTH       1048576
`define SCP_RST_ACT_HI  1'h1
`define SCP_ADDR_ZERO   20'h00000
`define SCP_ADDR_ONE    20'h00001
`define SCP_T_CYC_NS    100
`define SCP_CLK_NS      8
`define SCP_SKID_DEPTH  2
`endif

// >>> scp_pkg.sv
`default_nettype none
package scp_pkg;
	typedef enum logic [1:0] {
		SCP_ST_RESET   = 2'b00,
		SCP_ST_READ    = 2'b01,
		SCP_ST_DONE    = 2'b10,
		SCP_ST_STANDBY = 2'b11
	} scp_state_t;
endpackage
`default_nettype wire

// >>> scp_skid.sv
`default_nettype none
module scp_skid #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         flush_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);
	if (W < 1) begin
		$error("scp_skid: width below one");
	end
	// Two entries: a stalled receiver loses no word
	logic [W-1:0] mem_reg [2];
	logic [W-1:0] mem_next [2];
	logic [1:0]   cnt_reg, cnt_next;
	logic         push, pop;

	assign in_ready_o  = (cnt_reg != 2'h2);
	assign out_valid_o = (cnt_reg != 2'h0);
	assign out_data_o  = mem_reg[0];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_comb begin
		mem_next = mem_reg;
		cnt_next = cnt_reg;
		if (pop) begin
			mem_next[0] = mem_reg[1];
		end
		if (push) begin
			if (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)) begin
				mem_next[0] = in_data_i;
			end else begin
				mem_next[1] = in_data_i;
			end
		end
		cnt_next = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
		if (flush_i) begin
			cnt_next = 2'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg    <= 2'h0;
			mem_reg[0] <= '0;
			mem_reg[1] <= '0;
		end else begin
			cnt_reg <= cnt_next;
			mem_reg <= mem_next;
		end
	end

	a_skid_no_over: assert property (@(posedge clk_i) disable iff (rst_i)
		cnt_reg <= 2'h2) else $error("skid count overflow");
	a_skid_full_stall: assert property (@(posedge clk_i) disable iff (rst_i)
		(cnt_reg == 2'h2) |-> !in_ready_o) else $error("skid accepts when full");
	a_skid_hold_word: assert property (@(posedge clk_i) disable iff (rst_i)
		(out_valid_o && !out_ready_i && !flush_i) |=> out_valid_o && $stable(out_data_o))
		else $error("skid lost a stalled word");
endmodule
`default_nettype wire

// >>> scp_readout.sv
`include "scp_map.svh"
`default_nettype none
module scp_readout #(
	parameter int          ADDR_W     = `SCP_ADDR_W,
	parameter int          DEPTH      = `SCP_DEPTH,
	parameter logic        RST_ACT_HI = `SCP_RST_ACT_HI,
	parameter logic [ADDR_W-1:0] TERMINAL_COUNT = ADDR_W'(DEPTH - 1)
) (
	input  wire logic              CLK_SYS_I,
	input  wire logic              RST_I,
	input  wire logic              CONFIG_CLOCK_OUT_I,
	input  wire logic              RESET_OE_I,
	input  wire logic              CE_I,
	output logic                   DATA_O,
	output logic                   DATA_OE_O,
	output logic                   STANDBY_O,
	output logic                   REDUCED_O,
	output logic [ADDR_W-1:0]      ROM_ADDR_O,
	input  wire logic              ROM_DATA_I,
	output logic                   ROM_REQ_O,
	input  wire logic              ROM_ACK_I
);
	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	if (ADDR_W < 2 || ADDR_W > 31 || DEPTH < 2 || DEPTH > (1 << ADDR_W)) begin
		$error("scp_readout: unsupported geometry");
	end
	localparam logic [ADDR_W-1:0] ADDR_ZERO = ADDR_W'(`SCP_ADDR_ZERO);

	// ---------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------
	logic [1:0] clk_sync_reg, rst_sync_reg, ce_sync_reg;
	logic       clk_prev_reg;
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			clk_sync_reg <= 2'h0;
			rst_sync_reg <= {2{RST_ACT_HI}}; // Held in reset until the pin is seen
			ce_sync_reg  <= 2'h3;
			clk_prev_reg <= 1'b0;
		end else begin
			clk_sync_reg <= {clk_sync_reg[0], CONFIG_CLOCK_OUT_I};
			rst_sync_reg <= {rst_sync_reg[0], RESET_OE_I};
			ce_sync_reg  <= {ce_sync_reg[0], CE_I};
			clk_prev_reg <= clk_sync_reg[1];
		end
	end

	logic rise, rst_act, ce_high;
	assign rise    = clk_sync_reg[1] && !clk_prev_reg;
	assign rst_act = (rst_sync_reg[1] == RST_ACT_HI);
	assign ce_high = ce_sync_reg[1];

	// ---------------------------------------------
	// Address counter and state
	// ---------------------------------------------
	scp_pkg::scp_state_t state_reg, state_next;
	logic [ADDR_W-1:0]   addr_reg, addr_next;
	logic                past_tc_reg, past_tc_next;
	logic                fetch, buf_ready, buf_valid, buf_data;

	always_comb begin
		state_next   = state_reg;
		addr_next    = addr_reg;
		past_tc_next = past_tc_reg;
		if (rst_act) begin
			state_next   = ce_high ? scp_pkg::SCP_ST_STANDBY
			                       : scp_pkg::SCP_ST_RESET;
			addr_next    = ADDR_ZERO;
			past_tc_next = 1'b0;
		end else if (ce_high) begin
			state_next = scp_pkg::SCP_ST_STANDBY;
		end else begin
			case (state_reg)
				scp_pkg::SCP_ST_RESET,
				scp_pkg::SCP_ST_STANDBY: begin
					state_next = past_tc_reg ? scp_pkg::SCP_ST_DONE
					                         : scp_pkg::SCP_ST_READ;
				end
				scp_pkg::SCP_ST_READ: begin
					if (rise && buf_ready) begin
						if (addr_reg == TERMINAL_COUNT) begin
							addr_next    = ADDR_ZERO;
							past_tc_next = 1'b1;
							state_next   = scp_pkg::SCP_ST_DONE;
						end else begin
							addr_next = ADDR_W'(addr_reg + `SCP_ADDR_ONE);
						end
					end
				end
				scp_pkg::SCP_ST_DONE: begin
					state_next = scp_pkg::SCP_ST_DONE;
				end
				default: begin
					state_next = scp_pkg::SCP_ST_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			state_reg   <= scp_pkg::SCP_ST_RESET;
			addr_reg    <= ADDR_ZERO;
			past_tc_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			addr_reg    <= addr_next;
			past_tc_reg <= past_tc_next;
		end
	end

	// ---------------------------------------------
	// Memory fetch into skid buffer
	// ---------------------------------------------
	// Store answers with ack; one request per address, sent again after standby or reset stops the fetch
	logic req_reg, req_next;
	logic [ADDR_W-1:0] fetched_reg, fetched_next;
	logic have_reg, have_next;
	assign fetch = (state_reg == scp_pkg::SCP_ST_READ) && !rst_act && !ce_high;

	always_comb begin
		req_next     = req_reg;
		fetched_next = fetched_reg;
		have_next    = have_reg;
		if (!fetch || fetched_reg != addr_reg) begin
			have_next = 1'b0;
		end
		if (fetch && !have_reg && !req_reg) begin
			req_next     = 1'b1;
			fetched_next = addr_reg;
		end else if (req_reg && ROM_ACK_I) begin
			req_next  = 1'b0;
			have_next = (fetched_reg == addr_reg) && fetch;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			req_reg     <= 1'b0;
			fetched_reg <= ADDR_ZERO;
			have_reg    <= 1'b0;
		end else begin
			req_reg     <= req_next;
			fetched_reg <= fetched_next;
			have_reg    <= have_next;
		end
	end

	assign ROM_REQ_O  = req_reg;
	assign ROM_ADDR_O = fetched_reg;

	scp_skid #(
		.W(1)
	) u_skid (
		.clk_i      (CLK_SYS_I),
		.rst_i      (RST_I),
		.flush_i    (!fetch),
		.in_valid_i (req_reg && ROM_ACK_I && fetch && fetched_reg == addr_reg),
		.in_ready_o (buf_ready),
		.in_data_i  (ROM_DATA_I),
		.out_valid_o(buf_valid),
		.out_ready_i(rise),
		.out_data_o (buf_data)
	);

	// ---------------------------------------------
	// Output pin
	// ---------------------------------------------
	logic data_reg, data_next, oe_reg, oe_next;
	always_comb begin
		data_next = data_reg;
		oe_next   = 1'b0;
		if (fetch) begin
			oe_next = 1'b1;
			if (buf_valid) begin
				data_next = buf_data;
			end
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			data_reg <= 1'b0;
			oe_reg   <= 1'b0;
		end else begin
			data_reg <= data_next;
			oe_reg   <= oe_next;
		end
	end

	assign DATA_O    = data_reg;
	assign DATA_OE_O = oe_reg;
	assign STANDBY_O = (state_reg == scp_pkg::SCP_ST_STANDBY);
	assign REDUCED_O = past_tc_reg;

	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	a_reset_zero: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		rst_act |=> (addr_reg == `SCP_ADDR_ZERO) && !past_tc_reg)
		else $error("address not zero under reset");
	a_reset_float: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		rst_act |=> !DATA_OE_O) else $error("output driven under reset");
	a_ce_float: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		ce_high |=> !DATA_OE_O) else $error("output driven with chip enable high");
	a_standby_hold: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(ce_high && !rst_act) |=> $stable(addr_reg)) else $error("address moved in standby");
	a_step_one: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(state_reg == scp_pkg::SCP_ST_READ && fetch && rise && buf_ready
		 && addr_reg != TERMINAL_COUNT) |=> addr_reg == $past(addr_reg) + 1'b1)
		else $error("address did not step by one");
	a_tc_wrap: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(state_reg == scp_pkg::SCP_ST_READ && fetch && rise && buf_ready
		 && addr_reg == TERMINAL_COUNT) |=> addr_reg == `SCP_ADDR_ZERO && past_tc_reg)
		else $error("terminal count did not wrap");
	a_past_tc_float: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		past_tc_reg |=> !DATA_OE_O) else $error("output driven past terminal count");
	a_pol_select: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
		(rst_sync_reg[1] == RST_ACT_HI) |=> ##1 !DATA_OE_O)
		else $error("polarity ignored");

	c_readout: cover property (@(posedge CLK_SYS_I) fetch && rise && buf_valid);
	c_standby: cover property (@(posedge CLK_SYS_I) STANDBY_O);
	c_wrap:    cover property (@(posedge CLK_SYS_I) $rose(past_tc_reg));
endmodule
`default_nettype wire

// >>> scp_host.sv
`default_nettype none
module scp_host (
	input  wire logic clk_i,
	input  wire logic din_i,
	output logic      config_clock_out_o,
	output logic      init_o,
	output logic      done_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Idle levels
	// ----------------------------------------
	initial begin
		config_clock_out_o = 1'h0;
		init_o = 1'h1;
		done_o = 1'h0;
	end
	// ----------------------------------------
	// One clock bit, stands still after
	// ----------------------------------------
	// Seven cycles per phase keeps the period above 100 ns
	// Sampled just before the rise is driven: the memory steps after that rise
	task automatic clock_bit(input int hi, input int lo, output logic bit_o);
		@(posedge clk_i);
		#1 bit_o = din_i;
		config_clock_out_o = 1'h1;
		repeat (hi) @(posedge clk_i);
		#1 config_clock_out_o = 1'h0;
		repeat (lo) @(posedge clk_i);
	endtask
	task automatic set_lines(input logic init, input logic done);
		@(posedge clk_i);
		#1 init_o = init;
		done_o = done;
	endtask
endmodule
`default_nettype wire

// >>> tb_serial_config_prom_readout.sv
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin err_count++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_serial_config_prom_readout;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int AW = 3;
	localparam int DP = 8;
	logic          clk, rst, rom_req;
	logic          rom_data = 1'h0;
	logic          rom_ack = 1'h0;
	logic          data, data_oe, standby, reduced, config_clock_out, init, done, din, bit_v;
	logic          data_lo, data_oe_lo, req_lo, din_lo, bit_lo;
	logic [AW-1:0] rom_addr, addr_lo;
	logic [DP-1:0] mem;
	int            seed = 91;
	int            err_count = 0;
	int            tests_run = 0;
	int            cycles = 0;
	// Host input has a pull-up, so a floated line reads high
	assign din = data_oe ? data : 1'h1;
	scp_readout #(.ADDR_W(AW), .DEPTH(DP)) uut (.CLK_SYS_I(clk), .RST_I(rst),
		.CONFIG_CLOCK_OUT_I(config_clock_out), .RESET_OE_I(init), .CE_I(done), .DATA_O(data),
		.DATA_OE_O(data_oe), .STANDBY_O(standby), .REDUCED_O(reduced),
		.ROM_ADDR_O(rom_addr), .ROM_DATA_I(rom_data), .ROM_REQ_O(rom_req),
		.ROM_ACK_I(rom_ack));
	scp_host host (.clk_i(clk), .din_i(din), .config_clock_out_o(config_clock_out), .init_o(init), .done_o(done));
	// Second unit on the preferred active-low reset, storage answers at once
	assign din_lo = data_oe_lo ? data_lo : 1'h1;
	scp_readout #(.ADDR_W(AW), .DEPTH(DP), .RST_ACT_HI(1'h0)) uut_low (.CLK_SYS_I(clk),
		.RST_I(rst), .CONFIG_CLOCK_OUT_I(config_clock_out), .RESET_OE_I(!init), .CE_I(done),
		.DATA_O(data_lo), .DATA_OE_O(data_oe_lo), .STANDBY_O(), .REDUCED_O(),
		.ROM_ADDR_O(addr_lo), .ROM_DATA_I(mem[addr_lo]), .ROM_REQ_O(req_lo),
		.ROM_ACK_I(req_lo));
	// ----------------------------------------
	// Clock, storage with random stall
	// ----------------------------------------
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	always begin
		@(posedge clk);
		if (rom_req === 1'h1 && !rst) begin
			repeat (2'($random(seed))) @(posedge clk);
			if (rom_req === 1'h1) begin
				#1 rom_ack = 1'h1;
				rom_data = mem[rom_addr];
				@(posedge clk);
				#1 rom_ack = 1'h0;
			end
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic exp_bit(input int a);
		return (a < DP) ? mem[a] : 1'h1;
	endfunction
	task automatic read_run(input int first, input int n);
		int k;
		for (k = first; k < first + n; k++) begin
			bit_lo = din_lo;
			host.clock_bit(7 + 2'($random(seed)), 7 + 2'($random(seed)), bit_v);
			`CHK("data bit", exp_bit(k), bit_v)
			`CHK("low pol bit", exp_bit(k), bit_lo)
		end
	endtask
	task automatic settle_lines(input logic i, input logic d);
		host.set_lines(i, d);
		repeat (20) @(posedge clk);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		rst = 1'h1;
		mem = DP'($random(seed));
		repeat (12) @(posedge clk);
		#1 rst = 1'h0;
		repeat (20) @(posedge clk);
		host.clock_bit(7, 7, bit_v);
		`CHK("floated in reset", 1'h1, bit_v)
		`CHK("oe in reset", 1'h0, data_oe)
		`CHK("addr in reset", 3'h0, rom_addr)
		`CHK("oe low pol reset", 1'h0, data_oe_lo)
		settle_lines(1'h0, 1'h0);
		read_run(0, 4);
		$display("test head readout done");
		settle_lines(1'h0, 1'h1);
		`CHK("standby", 1'h1, standby)
		`CHK("oe in standby", 1'h0, data_oe)
		host.clock_bit(7, 7, bit_v);
		`CHK("floated in standby", 1'h1, bit_v)
		settle_lines(1'h0, 1'h0);
		`CHK("standby left", 1'h0, standby)
		read_run(4, 6);
		`CHK("reduced past end", 1'h1, reduced)
		`CHK("oe past end", 1'h0, data_oe)
		$display("test standby and end done");
		settle_lines(1'h1, 1'h1);
		`CHK("oe both active", 1'h0, data_oe)
		`CHK("standby in reset", 1'h1, standby)
		`CHK("oe low pol both", 1'h0, data_oe_lo)
		mem = DP'($random(seed));
		settle_lines(1'h0, 1'h0);
		`CHK("reduced cleared", 1'h0, reduced)
		read_run(0, 3);
		settle_lines(1'h0, 1'h1);
		`CHK("oe after done", 1'h0, data_oe)
		$display("test restart done");
		tally_and_finish();
	end
endmodule
`undef CHK
`default_nettype wire
